// ---- lsc_bus_master.sv ----
// Two-wire bus master model: it makes the link clock and drives the data line.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module lsc_bus_master (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sdaLow
);
   // ------------------------------------------------------------
   // Bus phases
   // ------------------------------------------------------------
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   // One quarter of the 160 ns link period, launched just after a clk edge.
   task automatic q;
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic bitIo(input logic b, output logic r);
      sdaLow = !b;
      q;
      scl = 1'b1;
      q;
      r = sda;
      q;
      scl = 1'b0;
      q;
   endtask
   task automatic start;
      sdaLow = 1'b0;
      q;
      scl = 1'b1;
      q;
      sdaLow = 1'b1;
      q;
      scl = 1'b0;
      q;
   endtask
   task automatic stop;
      sdaLow = 1'b1;
      q;
      scl = 1'b1;
      q;
      sdaLow = 1'b0;
      q;
   endtask
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(d[i], r);
      end
      bitIo(1'b1, r);
      ack = !r;
   endtask
   task automatic writeReg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
         input logic withData, output logic ok);
      logic k1, k2, k3;
      start;
      sendByte({a, 1'b0}, k1);
      sendByte(p, k2);
      k3 = 1'b1;
      if (withData) sendByte(d, k3);
      stop;
      ok = k1 & k2 & k3;
   endtask
   // The pointer is always written first; the data byte is refused with a release.
   task automatic readReg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
         output logic ok);
      logic k1, k2, k3, r;
      start;
      sendByte({a, 1'b0}, k1);
      sendByte(p, k2);
      start;
      sendByte({a, 1'b1}, k3);
      for (int i = 7; i >= 0; i--) begin
         bitIo(1'b1, d[i]);
      end
      bitIo(1'b1, r);
      stop;
      ok = k1 & k2 & k3;
   endtask
endmodule
`default_nettype wire

// ---- lsc_converter.sv ----
// Integration sequencer of the shared light converter: counts oscillator
// ticks to time an integration and charge-balance ticks to form the result.
// Assumes both tick inputs are single-cycle pulses already in the clk domain.
`timescale 1ns/100ps
`default_nettype none

module lsc_converter #(
   parameter int CountWidth = lsc_pkg::ADC_BITS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic oscTick,
   input wire logic chargeTick,
   input wire logic start,
   input wire logic abort,
   input wire logic syncStrobe,
   input wire logic extMode,
   input wire logic keepGoing,
   input wire logic [1:0] resolution,
   output logic done,
   output logic busy,
   output logic [CountWidth-1:0] adcOut,
   output logic [CountWidth-1:0] timerOut
);
   import lsc_pkg::*;

   lsc_conv_e convState;
   logic [16:0] cycleCount;
   logic [CountWidth-1:0] chargeCount;

   // ----------------------------------------------------------------------
   // Resolution decode
   // ----------------------------------------------------------------------
   // External timing always uses the full converter width.
   wire logic [4:0] intBits = 5'(ADC_FULL_BITS - {1'b0, resolution, 2'b00}); // R12
   wire logic [4:0] resBits = extMode ? ADC_FULL_BITS : intBits; // R12
   wire logic [16:0] cycleTarget = 17'h00001 << resBits; // R12
   wire logic [CountWidth-1:0] chargeMax = CountWidth'(cycleTarget - 17'h00001);
   wire logic intEnd = !extMode && (cycleCount == cycleTarget); // R12
   wire logic extEnd = extMode && syncStrobe; // R13
   wire logic integrationEnd = (convState == CONV_INT) && (intEnd || extEnd);
   wire logic [CountWidth-1:0] timerSat =
      cycleCount[16] ? {CountWidth{1'b1}} : cycleCount[CountWidth-1:0];

   assign busy = (convState != CONV_IDLE);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         convState <= CONV_IDLE;
         cycleCount <= 17'h00000;
         chargeCount <= '0;
         done <= 1'b0;
         adcOut <= '0;
         timerOut <= '0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            convState <= CONV_IDLE;
         end else if (start) begin
            convState <= extMode ? CONV_ARMED : CONV_INT;
            cycleCount <= 17'h00000;
            chargeCount <= '0;
         end else begin
            case (convState)
               CONV_IDLE: begin
                  convState <= CONV_IDLE;
               end
               CONV_ARMED: begin
                  if (syncStrobe) begin // R13
                     convState <= CONV_INT;
                     cycleCount <= 17'h00000;
                     chargeCount <= '0;
                  end
               end
               CONV_INT: begin
                  if (integrationEnd) begin
                     done <= 1'b1;
                     adcOut <= chargeCount;
                     timerOut <= timerSat;
                     cycleCount <= 17'h00000;
                     chargeCount <= '0;
                     // In continuous mode the end of an integration, by cycle count or sync write, opens the next; otherwise the converter returns to idle.
                     convState <= keepGoing ? CONV_INT : CONV_IDLE; // R14
                  end else begin
                     if (oscTick && cycleCount != CYCLE_LIMIT) begin
                        cycleCount <= cycleCount + 17'h00001;
                     end
                     if (chargeTick && chargeCount != chargeMax) begin
                        chargeCount <= chargeCount + 1'b1;
                     end
                  end
               end
               default: begin
                  convState <= CONV_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   chk_int_length: assert property (@(posedge clk) disable iff (!reset_n) // R12
      (convState == CONV_INT && !extMode && !start && !abort && cycleCount == cycleTarget)
         |=> done)
      else $error("internal integration did not end at its cycle count");

   chk_ext_interval: assert property (@(posedge clk) disable iff (!reset_n) // R13
      (convState == CONV_INT && extMode && syncStrobe && !start && !abort)
         |=> done && $stable(extMode))
      else $error("sync write did not end the external integration");

endmodule
`default_nettype wire

// ---- lsc_pkg.sv ----
// Constants shared by the light sensor control logic: register map, control
// field positions, reset values and the bus and measurement state sets.
// Assumes one 200 MHz clock domain with a synchronous active-low reset.
//
// Contract
// R1 - Address 1000100 or 1000101 by select pin.
// R2 - Compare first byte's upper seven; bit0 direction.
// R3 - Master frames with start, address, stop; drives clock.
// R4 - Receiver holds data low during acknowledge.
// R5 - Control register changes only by master write.
// R6 - Result registers read-only, converter or timer.
// R7 - Three zero-reset registers: control, result low/high.
// R8 - Power-down and zero results after power-up.
// R9 - One-time: convert once, power down, keep result.
// R10 - Continuous: convert repeatedly, overwrite result.
// R11 - Power-down command stops measuring.
// R12 - Internal timing: oscillator cycles, n=4/8/12/16.
// R13 - External timing: interval between two sync writes.
// R14 - Address top bit set restarts integration.
// R15 - One shared converter for both sources.
// R16 - Bit7 enable, bit6 continuous, bit5 infrared.
// R17 - Bits4:2 select timing, resolution, output.
// R18 - Timer code reads count, converter code reads result.
// R19 - Bits1:0 select one of four ranges.
// R20 - Written address is the held read pointer.
// R21 - Both result bytes update together.

package lsc_pkg;

   // ----------------------------------------------------------------------
   // Bus addressing
   // ----------------------------------------------------------------------
   localparam logic [6:0] SLAVE_ADDR_BASE = 7'h44;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int SYNC_ADDR_BIT = 7;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] REG_CONTROL = 8'h00;
   localparam logic [7:0] REG_RESULT_LO = 8'h01;
   localparam logic [7:0] REG_RESULT_HI = 8'h02;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ----------------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------------
   localparam int CTRL_ENABLE_BIT = 7;
   localparam int CTRL_CONT_BIT = 6;
   localparam int CTRL_SOURCE_BIT = 5;
   localparam int CTRL_TIMING_HI = 4;
   localparam int CTRL_TIMING_LO = 2;
   localparam int CTRL_SCALE_HI = 1;
   localparam int CTRL_SCALE_LO = 0;
   localparam logic [2:0] TIMING_EXT_ADC = 3'h4;
   localparam logic [2:0] TIMING_EXT_TIMER = 3'h5;

   // ----------------------------------------------------------------------
   // Converter sizing
   // ----------------------------------------------------------------------
   localparam int ADC_BITS = 16;
   localparam logic [4:0] ADC_FULL_BITS = 5'h10;
   localparam logic [16:0] CYCLE_LIMIT = 17'h10000;

   typedef enum logic [3:0] {
      BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_REG, BUS_ACK_REG,
      BUS_WDATA, BUS_ACK_WDATA, BUS_RDATA, BUS_RACK
   } lsc_bus_e;

   typedef enum logic [1:0] {MEAS_DOWN, MEAS_RUN} lsc_meas_e;

   typedef enum logic [1:0] {CONV_IDLE, CONV_ARMED, CONV_INT} lsc_conv_e;

endpackage

// ---- lsc_sensor_ctrl.sv ----
// Top of the light sensor control logic: two-wire bus slave, the three
// byte registers, the sync write and the measurement sequencing.
// Assumes the bus master and the front end run from clocks unrelated to clk.
`timescale 1ns/100ps
`default_nettype none

module lsc_sensor_ctrl #(
   parameter int ResultWidth = lsc_pkg::ADC_BITS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic addr_select_pin,
   input wire logic oscClk,
   input wire logic chargePulse,
   output logic frontEndOn,
   output logic sourceSelect,
   output logic [1:0] scaleSelect
);
   import lsc_pkg::*;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // Order: scl, sda, oscillator, charge pulse, address select.
   logic [4:0] pinMeta;
   logic [4:0] pinSync;
   logic [4:0] pinLast;
   wire logic [4:0] pinRaw = {addr_select_pin, chargePulse, oscClk, sdaIn, sclIn};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pinMeta <= 5'h1F;
         pinSync <= 5'h1F;
         pinLast <= 5'h1F;
      end else begin
         pinMeta <= pinRaw;
         pinSync <= pinMeta;
         pinLast <= pinSync;
      end
   end

   wire logic sclRise = pinSync[0] && !pinLast[0];
   wire logic sclFall = !pinSync[0] && pinLast[0];
   wire logic sclHigh = pinSync[0] && pinLast[0];
   wire logic sdaBit = pinSync[1];
   // Start and stop are only seen with the clock high on both samples.
   wire logic startCond = sclHigh && pinLast[1] && !pinSync[1]; // R3
   wire logic stopCond = sclHigh && !pinLast[1] && pinSync[1]; // R3
   wire logic oscTick = pinSync[2] && !pinLast[2];
   wire logic chargeTick = pinSync[3] && !pinLast[3];
   wire logic [6:0] ownAddr = SLAVE_ADDR_BASE | {6'h00, pinSync[4]}; // R1

   // ----------------------------------------------------------------------
   // Bus slave state
   // ----------------------------------------------------------------------
   lsc_bus_e busState;
   logic [3:0] bitCount;
   logic [7:0] rxShift;
   logic [7:0] txShift;
   logic sdaDrive;
   logic masterNack;
   logic [7:0] regPointer;
   logic [7:0] control;
   logic controlWrite;
   logic syncStrobe;
   logic [ResultWidth-1:0] lastAdc;
   logic [ResultWidth-1:0] lastTimer;
   logic [ResultWidth-1:0] resultWord;
   lsc_meas_e measState;

   wire logic byteDone = sclFall && (bitCount == BITS_PER_BYTE);
   // The ninth clock carries the acknowledge; counting it would shift every later byte.
   wire logic ackPhase = (busState == BUS_ACK_ADDR) || (busState == BUS_ACK_REG) ||
                         (busState == BUS_ACK_WDATA) || (busState == BUS_RACK); // R4
   wire logic addrHit = (rxShift[7:1] == ownAddr); // R2
   wire logic readDir = rxShift[0]; // R2
   wire logic regByteDone = byteDone && (busState == BUS_REG);
   wire logic isSyncAddr = rxShift[SYNC_ADDR_BIT]; // R14
   wire logic dataByteDone = byteDone && (busState == BUS_WDATA);
   wire logic writeControl = dataByteDone && (regPointer == REG_CONTROL); // R5

   // Unmapped pointers read as zero; result bytes are never writable.
   wire logic [7:0] readByte = (regPointer == REG_CONTROL) ? control :
                               (regPointer == REG_RESULT_LO) ? resultWord[7:0] :
                               (regPointer == REG_RESULT_HI) ? resultWord[15:8] :
                               UNMAPPED_READ; // R6 R7 R20

   assign sdaOut = 1'b0;
   assign sdaOe = sdaDrive;

   // ----------------------------------------------------------------------
   // Bit shifting
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bitCount <= 4'h0;
         rxShift <= 8'h00;
         masterNack <= 1'b0;
      end else if (startCond || (sclFall && bitCount == BITS_PER_BYTE)) begin
         bitCount <= 4'h0;
      end else if (sclRise) begin
         masterNack <= sdaBit;
         if (!ackPhase) begin
            rxShift <= {rxShift[6:0], sdaBit};
            if (bitCount != BITS_PER_BYTE) begin
               bitCount <= bitCount + 4'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Byte sequencing
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         busState <= BUS_IDLE;
         sdaDrive <= 1'b0;
         txShift <= 8'h00;
      end else if (startCond) begin
         busState <= BUS_ADDR;
         sdaDrive <= 1'b0;
      end else if (stopCond) begin
         busState <= BUS_IDLE;
         sdaDrive <= 1'b0;
      end else if (sclFall) begin
         case (busState)
            BUS_ADDR: begin
               if (byteDone && addrHit) begin
                  busState <= BUS_ACK_ADDR;
                  sdaDrive <= 1'b1; // R4
               end else if (byteDone) begin
                  busState <= BUS_IDLE;
               end
            end
            BUS_REG: begin
               if (byteDone) begin
                  busState <= BUS_ACK_REG;
                  sdaDrive <= 1'b1; // R4
               end
            end
            BUS_WDATA: begin
               if (byteDone) begin
                  busState <= BUS_ACK_WDATA;
                  sdaDrive <= 1'b1; // R4
               end
            end
            BUS_ACK_ADDR: begin
               if (readDir) begin
                  busState <= BUS_RDATA;
                  txShift <= readByte;
                  sdaDrive <= !readByte[7];
               end else begin
                  busState <= BUS_REG;
                  sdaDrive <= 1'b0;
               end
            end
            BUS_ACK_REG, BUS_ACK_WDATA: begin
               busState <= BUS_WDATA;
               sdaDrive <= 1'b0;
            end
            BUS_RDATA: begin
               if (byteDone) begin
                  busState <= BUS_RACK;
                  sdaDrive <= 1'b0;
               end else begin
                  txShift <= {txShift[6:0], 1'b0};
                  sdaDrive <= !txShift[6];
               end
            end
            BUS_RACK: begin
               // The pointer does not advance, so a burst repeats one register.
               if (!masterNack) begin // R4
                  busState <= BUS_RDATA;
                  txShift <= readByte;
                  sdaDrive <= !readByte[7];
               end else begin
                  busState <= BUS_IDLE;
               end
            end
            default: begin
               busState <= BUS_IDLE;
               sdaDrive <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registers and strobes
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regPointer <= REG_CONTROL;
         control <= CONTROL_RESET;
         controlWrite <= 1'b0;
         syncStrobe <= 1'b0;
      end else begin
         controlWrite <= writeControl;
         syncStrobe <= regByteDone && isSyncAddr; // R14
         if (regByteDone && !isSyncAddr) begin
            regPointer <= rxShift; // R20
         end
         if (writeControl) begin
            control <= rxShift; // R5
         end
      end
   end

   // ----------------------------------------------------------------------
   // Measurement sequencing
   // ----------------------------------------------------------------------
   wire logic enabled = control[CTRL_ENABLE_BIT]; // R16
   wire logic continuous = control[CTRL_CONT_BIT]; // R16
   wire logic [2:0] timingCode = control[CTRL_TIMING_HI:CTRL_TIMING_LO]; // R17
   wire logic extMode = timingCode[2]; // R17
   wire logic timingValid = !(timingCode[2] && timingCode[1]); // R17
   wire logic timerSelected = (timingCode == TIMING_EXT_TIMER); // R18
   wire logic startMeas = controlWrite && enabled && timingValid;
   wire logic stopMeas = controlWrite && !(enabled && timingValid); // R11
   wire logic convDone;
   wire logic convBusy;
   wire logic [ResultWidth-1:0] convAdc;
   wire logic [ResultWidth-1:0] convTimer;
   wire logic [ResultWidth-1:0] next_resultWord = timerSelected ? lastTimer : lastAdc; // R6 R18

   // The front end follows the sequencer; source and scale steer it directly.
   assign frontEndOn = (measState == MEAS_RUN);
   assign sourceSelect = control[CTRL_SOURCE_BIT]; // R15 R16
   assign scaleSelect = control[CTRL_SCALE_HI:CTRL_SCALE_LO]; // R19

   lsc_converter #(
      .CountWidth(ResultWidth)
   ) converter (
      .clk(clk),
      .reset_n(reset_n),
      .oscTick(oscTick),
      .chargeTick(chargeTick),
      .start(startMeas),
      .abort(stopMeas),
      .syncStrobe(syncStrobe),
      .extMode(extMode),
      .keepGoing(continuous),
      .resolution(control[CTRL_TIMING_LO+1:CTRL_TIMING_LO]),
      .done(convDone),
      .busy(convBusy),
      .adcOut(convAdc),
      .timerOut(convTimer)
   );

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         measState <= MEAS_DOWN; // R8
         lastAdc <= RESULT_RESET;
         lastTimer <= RESULT_RESET;
         resultWord <= RESULT_RESET; // R8
      end else begin
         resultWord <= next_resultWord; // R21
         if (convDone) begin
            lastAdc <= convAdc; // R10 R21
            lastTimer <= convTimer; // R21
         end
         if (startMeas) begin
            measState <= MEAS_RUN;
         end else if (stopMeas) begin
            measState <= MEAS_DOWN; // R11
         end else if (convDone && !continuous) begin
            measState <= MEAS_DOWN; // R9
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   chk_addr_ack: assert property (@(posedge clk) disable iff (!reset_n) // R1
      (busState == BUS_ADDR && byteDone && !startCond && !stopCond && addrHit)
         |=> busState == BUS_ACK_ADDR && sdaOe)
      else $error("matching address was not acknowledged");

   chk_addr_miss: assert property (@(posedge clk) disable iff (!reset_n) // R2
      (busState == BUS_ADDR && byteDone && !startCond && !stopCond && !addrHit)
         |=> busState == BUS_IDLE && !sdaOe)
      else $error("foreign address was acknowledged");

   chk_ack_hold: assert property (@(posedge clk) disable iff (!reset_n) // R4
      (busState == BUS_ACK_REG || busState == BUS_ACK_WDATA) |-> sdaOe)
      else $error("data byte acknowledge released early");

   chk_ctrl_stable: assert property (@(posedge clk) disable iff (!reset_n) // R5
      !writeControl |=> $stable(control))
      else $error("control register changed without a write");

   chk_power_up: assert property (@(posedge clk) disable iff (!reset_n) // R8
      $rose(reset_n) |-> resultWord == RESULT_RESET && measState == MEAS_DOWN)
      else $error("not powered down with zero results after reset");

   chk_oneshot_stop: assert property (@(posedge clk) disable iff (!reset_n) // R9
      (convDone && !continuous && !controlWrite) |=> measState == MEAS_DOWN ##1 !convBusy)
      else $error("one-time measurement did not power down");

   chk_cont_update: assert property (@(posedge clk) disable iff (!reset_n) // R10
      (convDone && continuous && !controlWrite)
         |=> measState == MEAS_RUN && lastAdc == $past(convAdc))
      else $error("continuous measurement did not refresh the result");

   chk_stop_cmd: assert property (@(posedge clk) disable iff (!reset_n) // R11
      stopMeas |=> measState == MEAS_DOWN ##1 !convBusy)
      else $error("power-down write did not stop measuring");

   chk_sync_pulse: assert property (@(posedge clk) disable iff (!reset_n) // R14
      (regByteDone && isSyncAddr && !startCond && !stopCond)
         |=> syncStrobe && $stable(regPointer))
      else $error("sync address write did not pulse the restart");

   chk_result_pair: assert property (@(posedge clk) disable iff (!reset_n) // R21
      ($changed(lastAdc) || $changed(lastTimer)) |-> $past(convDone))
      else $error("result bytes changed outside a conversion end");

   chk_result_sel: assert property (@(posedge clk) disable iff (!reset_n) // R18
      timerSelected |=> resultWord == $past(lastTimer))
      else $error("timer code did not present the timer count");

endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the light sensor control top.
// Assumes the bus master model; oscillator and charge pulses come from here.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import lsc_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic addrPin = 1'b0;
   logic oscClk = 1'b0;
   logic oscDiv = 1'b0;
   logic halfChg = 1'b0;
   logic [1:0] ph = 2'h0;
   int oscLeft = -1;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   logic scl, mLow, sdaOut, sdaOe, frontEndOn, sourceSelect, ok;
   logic [1:0] scaleSelect;
   logic [15:0] res;
   logic [23:0] rows [3] = '{24'h8C000F, 24'hA900FF, 24'h860FFF};
   wire sda = !mLow && (sdaOe ? sdaOut : 1'b1);
   wire chargePulse = halfChg ? oscDiv : oscClk;
   lsc_sensor_ctrl dut (.clk(clk), .reset_n(reset_n), .sclIn(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_select_pin(addrPin), .oscClk(oscClk),
      .chargePulse(chargePulse), .frontEndOn(frontEndOn), .sourceSelect(sourceSelect),
      .scaleSelect(scaleSelect));
   lsc_bus_master master (.clk(clk), .sda(sda), .scl(scl), .sdaLow(mLow));
   // ------------------------------------------------------------
   // Clocks and checks
   // ------------------------------------------------------------
   always #2.5 clk = ~clk;
   // The oscillator can be stopped or given an exact edge count for timed windows.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      ph <= ph + 2'h1;
      if (ph == 2'h3 && oscClk) oscClk <= 1'b0;
      else if (ph == 2'h3 && oscLeft != 0) begin
         oscClk <= 1'b1;
         oscDiv <= !oscDiv;
         if (oscLeft > 0) oscLeft <= oscLeft - 1;
      end
      if (cyc == 90000) begin
         err_total = err_total + 1;
         summarize;
      end
   end
   task automatic summarize;
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chkData(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkFlag(input logic got, input logic exp);
      chkData({15'h0, got}, {15'h0, exp});
   endtask
   task automatic rdReg(input logic [6:0] a, input logic [7:0] p);
      res[15:8] = 8'h00;
      master.readReg(a, p, res[7:0], ok);
   endtask
   task automatic rdResult;
      master.readReg(7'h44, REG_RESULT_LO, res[7:0], ok);
      master.readReg(7'h44, REG_RESULT_HI, res[15:8], ok);
   endtask
   task automatic wrCtrl(input logic [7:0] d);
      master.writeReg(7'h44, REG_CONTROL, d, 1'b1, ok);
   endtask
   task automatic waitFe(input logic v, input int lim);
      for (int i = 0; i < lim && frontEndOn !== v; i++) begin
         @(posedge clk);
         #1;
      end
      chkFlag(frontEndOn, v);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1;
      reset_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      rdResult;
      chkData(res, RESULT_RESET);
      rdReg(7'h44, REG_CONTROL);
      chkData(res, {8'h00, CONTROL_RESET});
      chkFlag(frontEndOn, 1'b0);
      for (int i = 0; i < 3; i++) begin
         wrCtrl(rows[i][23:16]);
         chkFlag(ok, 1'b1);
         waitFe(1'b1, 400);
         chkFlag(sourceSelect, rows[i][21]);
         chkData({14'h0, scaleSelect}, {14'h0, rows[i][17:16]});
         waitFe(1'b0, 40000);
         rdResult;
         chkData(res, rows[i][15:0]);
         rdReg(7'h44, REG_CONTROL);
         chkData(res, {8'h00, rows[i][23:16]});
      end
      wrCtrl(8'hCC);
      repeat (600) @(posedge clk);
      #1;
      chkFlag(frontEndOn, 1'b1);
      rdResult;
      chkData(res, 16'h000F);
      wrCtrl(8'h00);
      waitFe(1'b0, 100);
      master.writeReg(7'h44, REG_RESULT_LO, 8'h55, 1'b1, ok);
      rdResult;
      chkData(res, 16'h000F);
      rdReg(7'h44, 8'h03);
      chkData(res, {8'h00, UNMAPPED_READ});
      // Stopped oscillator makes the timed window exact: 20 timer and 10 charge edges.
      oscLeft = 0;
      halfChg = 1'b1;
      wrCtrl(8'hD4);
      master.writeReg(7'h44, 8'h80, 8'h00, 1'b0, ok);
      oscLeft = 20;
      repeat (200) @(posedge clk);
      #1;
      master.writeReg(7'h44, 8'h80, 8'h00, 1'b0, ok);
      rdResult;
      chkData(res, 16'h0014);
      wrCtrl(8'hD0);
      rdResult;
      chkData(res, 16'h000A);
      halfChg = 1'b0;
      oscLeft = -1;
      wrCtrl(8'h98);
      waitFe(1'b0, 200);
      repeat (200) @(posedge clk);
      #1;
      chkFlag(frontEndOn, 1'b0);
      addrPin = 1'b1;
      rdReg(7'h45, REG_CONTROL);
      chkFlag(ok, 1'b1);
      chkData(res, 16'h0098);
      rdReg(7'h44, REG_CONTROL);
      chkFlag(ok, 1'b0);
      summarize;
   end
endmodule
`default_nettype wire
